// file: scg1_consts.svh
/*
  offsets, field positions, reset values and codes for the sleep clock gating register block.
  assumes a 12-bit byte address on the register bus.
*/
`ifndef SCG1_CONSTS_SVH
`define SCG1_CONSTS_SVH
`define SCG1_ADDR_W        12
`define SCG1_OFS_CTRL      12'h114
`define SCG1_OFS_STATUS    12'h200
`define SCG1_OFS_MASK      12'h204
`define SCG1_CTRL_RESET    32'h00000000
`define SCG1_CTRL_WMASK    32'h030F5033
`define SCG1_BIT_CMP1      25
`define SCG1_BIT_CMP0      24
`define SCG1_BIT_GPTM3     19
`define SCG1_BIT_GPTM0     16
`define SCG1_BIT_TW1       14
`define SCG1_BIT_TW0       12
`define SCG1_BIT_SS1       5
`define SCG1_BIT_SS0       4
`define SCG1_BIT_AS1       1
`define SCG1_BIT_AS0       0
`define SCG1_EVT_W         2
`define SCG1_EVT_FAULT     0
`define SCG1_EVT_RSVD      1
`define SCG1_UNITS         12
`define SCG1_RESP_OKAY     2'h0
`define SCG1_RESP_SLVERR   2'h2
`endif

// file: scg1_pkg.sv
/*
  types of the sleep clock gating register block.
  assumes scg1_consts.svh is on the include path.
*/
package scg1_pkg;
  typedef struct packed {
    logic cmp1;
    logic cmp0;
    logic gptm3;
    logic gptm2;
    logic gptm1;
    logic gptm0;
    logic twowire1;
    logic twowire0;
    logic syncser1;
    logic syncser0;
    logic asyncser1;
    logic asyncser0;
  } scg1_units_type;
endpackage

// file: scg1_gate.sv
/*
  per-unit sleep clock enables, one flop per unit.
  assumes sleep and auto gating inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ns
`include "scg1_consts.svh"
module scg1_gate
  import scg1_pkg::*;
#(
  parameter int UNITS = `SCG1_UNITS
)
(
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             sleep_i,
  input  wire logic             auto_clock_gating_i,
  input  wire logic [UNITS-1:0] gate_bits_i,
  output logic      [UNITS-1:0] clk_en_o
);
  wire             gating_active = sleep_i & auto_clock_gating_i;
  wire [UNITS-1:0] next_clk_en;

  // one enable term per unit, all held in a single register
  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++)
    begin : g_unit
      assign next_clk_en[gi] = ~gating_active | gate_bits_i[gi];
    end
  endgenerate

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      clk_en_o <= '0;
    else
      clk_en_o <= next_clk_en;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_SLEEP_GATED_OFF: assert property (gating_active && gate_bits_i == '0 |=> clk_en_o == '0)
    else $error("unit clocked in sleep with its gate bit clear");
  AST_AWAKE_ALL_ON: assert property (!reset_i && !gating_active |=> clk_en_o == '1)
    else $error("gating applied outside sleep");
endmodule

// file: scg1_fault.sv
/*
  checks peripheral accesses against the unit clock enables.
  assumes an access request is a one-cycle pulse with a unit index.
*/
`timescale 1ns/1ns
`include "scg1_consts.svh"
module scg1_fault
#(
  parameter int UNITS = `SCG1_UNITS
)
(
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             acc_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [UNITS-1:0] clk_en_i,
  output logic                  fault_o,
  output logic                  done_o
);
  wire sel_valid = (sel_i < 4'(UNITS));
  wire sel_on    = sel_valid & clk_en_i[sel_i];

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      fault_o <= 1'b0;
      done_o  <= 1'b0;
    end
    else
    begin
      fault_o <= acc_i & ~sel_on;
      done_o  <= acc_i & sel_on;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  AST_FAULT_WHEN_GATED: assert property (acc_i && !sel_on |=> fault_o && !done_o)
    else $error("access to gated unit not faulted");
  AST_DONE_WHEN_CLOCKED: assert property (acc_i && sel_on |=> done_o && !fault_o)
    else $error("access to clocked unit faulted");
endmodule

// file: scg1_top.sv
/*
  sleep clock gating control register with an axi4-lite slave, status, mask and interrupt.
  assumes all inputs are synchronous to mclk_i; the run-mode configuration block supplies
  the auto clock gating level and the power controller the sleep level.
*/
// Implementation choices: the AXI4-Lite register port and the address map.
// Operation
// - bit 25 enables the second analog comparator clock during sleep.
// - bit 24 enables the first analog comparator clock during sleep.
// - bits 19 to 16 enable the sleep clocks of timers three down to zero.
// - bits 14 and 12 enable the sleep clocks of two-wire modules one and zero.
// - bits 5 and 4 enable the sleep clocks of synchronous serial modules one and zero.
// - bits 1 and 0 enable the sleep clocks of asynchronous serial ports one and zero.
// - a set bit clocks its unit and a clear bit leaves it unclocked and disabled.
// - any access to a unit whose clock is off ends in a bus fault.
// - every gating bit resets to zero.
// - reserved fields are read-only and read as zero.
// - the gating applies only in sleep with automatic clock gating enabled; the code also holds every unit enable low while reset_i is high.
// - the register is a 32-bit read/write word at offset 0x114 resetting to zero.
`timescale 1ns/1ns
`include "scg1_consts.svh"
module scg1_top
  import scg1_pkg::*;
#(
  parameter int ADDR_W = `SCG1_ADDR_W
)
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              sleep_i,
  input  wire logic              auto_clock_gating_i,
  input  wire logic              periph_acc_i,
  input  wire logic [3:0]        periph_sel_i,
  output logic                   periph_fault_o,
  output logic                   periph_done_o,
  output scg1_units_type         unit_clk_en_o,
  output logic                   irq_o
);
  logic [31:0]            ctrl;
  logic [`SCG1_EVT_W-1:0] status;
  logic [`SCG1_EVT_W-1:0] mask;
  logic                   aw_full;
  logic                   w_full;
  logic [ADDR_W-1:0]      aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;

  // bus handshakes
  wire aw_hs    = s_axi_awvalid_i & s_axi_awready_o;
  wire w_hs     = s_axi_wvalid_i & s_axi_wready_o;
  wire ar_hs    = s_axi_arvalid_i & s_axi_arready_o;
  wire do_write = aw_full & w_full & ~s_axi_bvalid_o;

  wire next_aw_full = aw_hs | (aw_full & ~do_write);
  wire next_w_full  = w_hs | (w_full & ~do_write);
  wire next_bvalid  = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);
  wire next_rvalid  = ar_hs | (s_axi_rvalid_o & ~s_axi_rready_i);

  // write decode
  wire        wr_ctrl   = do_write & (aw_addr == `SCG1_OFS_CTRL);
  wire        wr_status = do_write & (aw_addr == `SCG1_OFS_STATUS);
  wire        wr_mask   = do_write & (aw_addr == `SCG1_OFS_MASK);
  wire        wr_hit    = wr_ctrl | wr_status | wr_mask;
  wire [31:0] strb_bits = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wr_bits   = w_data & strb_bits;
  wire [31:0] next_ctrl = ((ctrl & ~strb_bits) | wr_bits) & `SCG1_CTRL_WMASK;
  wire        rsvd_hit  = wr_ctrl & ((wr_bits & ~`SCG1_CTRL_WMASK) != 32'h00000000);

  wire [`SCG1_EVT_W-1:0] next_mask = (mask & ~strb_bits[`SCG1_EVT_W-1:0]) | wr_bits[`SCG1_EVT_W-1:0];

  // read decode
  wire rd_ctrl   = (s_axi_araddr_i == `SCG1_OFS_CTRL);
  wire rd_status = (s_axi_araddr_i == `SCG1_OFS_STATUS);
  wire rd_mask   = (s_axi_araddr_i == `SCG1_OFS_MASK);
  wire rd_hit    = rd_ctrl | rd_status | rd_mask;
  wire [31:0] rd_val =
    rd_ctrl   ? ctrl :
    rd_status ? {{(32-`SCG1_EVT_W){1'b0}}, status} :
    rd_mask   ? {{(32-`SCG1_EVT_W){1'b0}}, mask} :
    32'h00000000;

  // gate bits in unit order, most significant unit first
  wire [`SCG1_UNITS-1:0] gate_bits = {
    ctrl[`SCG1_BIT_CMP1],
    ctrl[`SCG1_BIT_CMP0],
    ctrl[`SCG1_BIT_GPTM3:`SCG1_BIT_GPTM0],
    ctrl[`SCG1_BIT_TW1],
    ctrl[`SCG1_BIT_TW0],
    ctrl[`SCG1_BIT_SS1],
    ctrl[`SCG1_BIT_SS0],
    ctrl[`SCG1_BIT_AS1],
    ctrl[`SCG1_BIT_AS0]
  };

  logic [`SCG1_UNITS-1:0] clk_en;
  logic                   fault;
  logic                   done;

  // events: access fault, write of ones into reserved positions
  wire [`SCG1_EVT_W-1:0] evt = {rsvd_hit, fault};
  wire [`SCG1_EVT_W-1:0] clr = wr_status ? wr_bits[`SCG1_EVT_W-1:0] : '0;
  wire [`SCG1_EVT_W-1:0] next_status = (status & ~clr) | evt;

  scg1_gate #(
    .UNITS (`SCG1_UNITS)
  ) u_gate (
    .mclk_i              (mclk_i),
    .reset_i             (reset_i),
    .sleep_i             (sleep_i),
    .auto_clock_gating_i (auto_clock_gating_i),
    .gate_bits_i         (gate_bits),
    .clk_en_o            (clk_en)
  );

  scg1_fault #(
    .UNITS (`SCG1_UNITS)
  ) u_fault (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .acc_i    (periph_acc_i),
    .sel_i    (periph_sel_i),
    .clk_en_i (clk_en),
    .fault_o  (fault),
    .done_o   (done)
  );

  assign unit_clk_en_o  = scg1_units_type'(clk_en);
  assign periph_fault_o = fault;
  assign periph_done_o  = done;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      ctrl <= `SCG1_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= next_ctrl;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      status <= '0;
      mask   <= '0;
      irq_o  <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask   <= wr_mask ? next_mask : mask;
      irq_o  <= |(next_status & (wr_mask ? next_mask : mask));
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      aw_full         <= 1'b0;
      w_full          <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `SCG1_RESP_OKAY;
    end
    else
    begin
      aw_full         <= next_aw_full;
      w_full          <= next_w_full;
      s_axi_awready_o <= ~next_aw_full;
      s_axi_wready_o  <= ~next_w_full;
      s_axi_bvalid_o  <= next_bvalid;
      if (do_write)
        s_axi_bresp_o <= wr_hit ? `SCG1_RESP_OKAY : `SCG1_RESP_SLVERR;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      aw_addr <= '0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (aw_hs)
        aw_addr <= s_axi_awaddr_i;
      if (w_hs)
      begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `SCG1_RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= ~next_rvalid;
      s_axi_rvalid_o  <= next_rvalid;
      if (ar_hs)
      begin
        s_axi_rdata_o <= rd_val;
        s_axi_rresp_o <= rd_hit ? `SCG1_RESP_OKAY : `SCG1_RESP_SLVERR;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  wire gating_active = sleep_i & auto_clock_gating_i;

  sequence s_full_ctrl_write;
    wr_ctrl && w_strb == 4'hF;
  endsequence

  sequence s_ctrl_read;
    ar_hs && rd_ctrl;
  endsequence

  AST_RESET_CLEARS: assert property (disable iff (1'b0) $past(reset_i) |-> ctrl == 32'h00000000)
    else $error("control register not zero after reset");
  AST_RSVD_ZERO: assert property ((ctrl & ~`SCG1_CTRL_WMASK) == 32'h00000000)
    else $error("reserved control bit set");
  AST_WRITE_MASKED: assert property (s_full_ctrl_write |=> ctrl == ($past(w_data) & `SCG1_CTRL_WMASK))
    else $error("control write not stored with reserved bits dropped");
  AST_READ_CTRL: assert property (s_ctrl_read |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h0
                                  && s_axi_rdata_o == $past(ctrl))
    else $error("control read returned wrong value");
  AST_CMP1_GATE: assert property (gating_active |=> unit_clk_en_o.cmp1 == $past(ctrl[25]))
    else $error("comparator one enable does not follow bit 25");
  AST_CMP0_GATE: assert property (gating_active |=> unit_clk_en_o.cmp0 == $past(ctrl[24]))
    else $error("comparator zero enable does not follow bit 24");
  AST_TIMER_GATE: assert property (gating_active |=> {unit_clk_en_o.gptm3, unit_clk_en_o.gptm2,
                                   unit_clk_en_o.gptm1, unit_clk_en_o.gptm0} == $past(ctrl[19:16]))
    else $error("timer enables do not follow bits 19 to 16");
  AST_TWOWIRE_GATE: assert property (gating_active |=> unit_clk_en_o.twowire1 == $past(ctrl[14])
                                     && unit_clk_en_o.twowire0 == $past(ctrl[12]))
    else $error("two-wire enables do not follow bits 14 and 12");
  AST_SYNCSER_GATE: assert property (gating_active |=> unit_clk_en_o.syncser1 == $past(ctrl[5])
                                     && unit_clk_en_o.syncser0 == $past(ctrl[4]))
    else $error("synchronous serial enables do not follow bits 5 and 4");
  AST_ASYNCSER_GATE: assert property (gating_active |=> unit_clk_en_o.asyncser1 == $past(ctrl[1])
                                      && unit_clk_en_o.asyncser0 == $past(ctrl[0]))
    else $error("asynchronous serial enables do not follow bits 1 and 0");
  AST_FAULT_STICKY: assert property (fault |=> status[`SCG1_EVT_FAULT])
    else $error("bus fault not recorded in status");
  AST_AWAKE_IGNORES: assert property ((!reset_i && !gating_active) ##1 !gating_active |-> clk_en == '1)
    else $error("gating applied outside sleep");

  // bus walks: execution one edge after both write halves, answers released when taken
  sequence s_write_exec;
    aw_full && w_full && !s_axi_bvalid_o;
  endsequence

  sequence s_write_answer;
    s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
  endsequence

  sequence s_read_answer;
    s_axi_rvalid_o && !s_axi_arready_o;
  endsequence

  sequence s_read_release;
    !s_axi_rvalid_o && s_axi_arready_o;
  endsequence

  sequence s_status_clear;
    wr_status && evt == '0;
  endsequence

  AST_WRITE_ANSWER: assert property (s_write_exec |=> s_write_answer)
    else $error("write not answered one edge after both halves arrived");
  AST_WRITE_RELEASE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response held after it was taken");
  AST_WRITE_UNMAPPED: assert property (do_write && !wr_hit |=> s_axi_bresp_o == `SCG1_RESP_SLVERR)
    else $error("write to unmapped address not refused");
  AST_READ_ANSWER: assert property (ar_hs |=> s_read_answer)
    else $error("read not answered one edge after the address");
  AST_READ_RELEASE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> s_read_release)
    else $error("read data held after it was taken");
  AST_READ_UNMAPPED: assert property (ar_hs && !rd_hit |=> s_axi_rresp_o == `SCG1_RESP_SLVERR
                                      && s_axi_rdata_o == 32'h00000000)
    else $error("read of unmapped address not refused");
  AST_READ_STATUS: assert property (ar_hs && rd_status |=> s_axi_rdata_o
                                    == {{(32-`SCG1_EVT_W){1'b0}}, $past(status)})
    else $error("status read returned wrong value");
  AST_READ_MASK: assert property (ar_hs && rd_mask |=> s_axi_rdata_o
                                  == {{(32-`SCG1_EVT_W){1'b0}}, $past(mask)})
    else $error("mask read returned wrong value");
  AST_CTRL_HELD: assert property (!wr_ctrl |=> $stable(ctrl))
    else $error("control register changed without a write");
  AST_STROBE_KEEP: assert property (wr_ctrl |=> (ctrl & ~$past(strb_bits))
                                    == ($past(ctrl) & ~$past(strb_bits)))
    else $error("control bytes outside the strobes changed");

  // status: a new event wins over a clear in the same cycle
  AST_STATUS_CLEAR: assert property (s_status_clear |=> (status & $past(clr)) == '0)
    else $error("status bit not cleared by writing one");
  AST_STATUS_SET_WINS: assert property (evt != '0 |=> (status & $past(evt)) == $past(evt))
    else $error("status event lost");
  AST_MASK_HELD: assert property (!wr_mask |=> $stable(mask))
    else $error("mask changed without a write");
  AST_IRQ_LEVEL: assert property (irq_o == |(status & mask))
    else $error("interrupt does not follow unmasked status");
endmodule

// file: tb_scg1_top.sv
/*
  self-checking testbench for the sleep clock gating register block: axi4-lite register access,
  per-unit sleep clock enables, peripheral access faults and the interrupt.
  assumes scg1_consts.svh and scg1_pkg are compiled first; one clock at 20 MHz.
*/
`timescale 1ns/1ns
`include "scg1_consts.svh"
module tb_scg1_top
  import scg1_pkg::*;
;
  localparam int LIMIT = 20000;
  logic                      mclk;
  logic                      reset;
  logic [`SCG1_ADDR_W-1:0]   awaddr;
  logic                      awvalid;
  logic                      awready;
  logic [31:0]               wdata;
  logic [3:0]                wstrb;
  logic                      wvalid;
  logic                      wready;
  logic [1:0]                bresp;
  logic                      bvalid;
  logic                      bready;
  logic [`SCG1_ADDR_W-1:0]   araddr;
  logic                      arvalid;
  logic                      arready;
  logic [31:0]               rdata;
  logic [1:0]                rresp;
  logic                      rvalid;
  logic                      rready;
  logic                      sleep;
  logic                      auto_clock_gating;
  logic                      acc;
  logic [3:0]                psel;
  logic                      fault;
  logic                      done;
  scg1_units_type            clk_en;
  logic                      irq;
  int                        err_total;
  int                        total_checks;
  int                        cyc;
  logic [1:0]                bq[$];
  logic [33:0]               rq[$];
  logic [1:0]                pq[$];
  logic [31:0]               ctrl_exp;
  logic [11:0]               en_exp;

  scg1_top DUT (.mclk_i(mclk), .reset_i(reset), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_i(sleep),
    .auto_clock_gating_i(auto_clock_gating), .periph_acc_i(acc), .periph_sel_i(psel), .periph_fault_o(fault),
    .periph_done_o(done), .unit_clk_en_o(clk_en), .irq_o(irq));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // unit order cmp1 down to asyncser0, matching the enable struct
  function automatic logic [11:0] map_units(input logic [31:0] c);
    return {c[`SCG1_BIT_CMP1], c[`SCG1_BIT_CMP0], c[`SCG1_BIT_GPTM3:`SCG1_BIT_GPTM0], c[`SCG1_BIT_TW1],
            c[`SCG1_BIT_TW0], c[`SCG1_BIT_SS1], c[`SCG1_BIT_SS0], c[`SCG1_BIT_AS1], c[`SCG1_BIT_AS0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // result watcher: every answer takes the oldest note of its kind
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc >= LIMIT)
    begin
      err_total++;
      end_sim();
    end
    if (bvalid === 1'b1 && bready)
      check(32'(bresp), bq.size() ? 32'(bq.pop_front()) : 32'hFFFFFFFF);
    if (rvalid === 1'b1 && rready)
    begin
      if (rq.size() == 0)
        check(32'h0, 32'hFFFFFFFF);
      else
      begin
        check(rdata, rq[0][31:0]);
        check(32'(rresp), 32'(rq[0][33:32]));
        void'(rq.pop_front());
      end
    end
    if (fault === 1'b1 || done === 1'b1)
      check({30'h0, fault, done}, pq.size() ? 32'(pq.pop_front()) : 32'h0);
  end

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge mclk);
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge mclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge mclk);
  endtask

  task automatic wr_ctrl(input logic [31:0] d, input logic [3:0] s);
    logic [31:0] sm;
    sm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & `SCG1_CTRL_WMASK;
    ctrl_exp = (ctrl_exp & ~sm) | (d & sm);
    axi_write(`SCG1_OFS_CTRL, d, s, `SCG1_RESP_OKAY);
  endtask

  task automatic check_en;
    repeat (2) @(posedge mclk);
    en_exp = (sleep && auto_clock_gating) ? map_units(ctrl_exp) : 12'hFFF;
    check({20'h0, clk_en}, {20'h0, en_exp});
  endtask

  // back-to-back accesses; fixed unit 4'(f) if f is 0 or more, random if f is negative
  task automatic periph_run(input int n, input int f);
    logic [3:0] s;
    for (int i = 0; i < n; i++)
    begin
      s = (f >= 0) ? 4'(f) : 4'($urandom_range(15, 0));
      pq.push_back((s >= 4'hC || !en_exp[s]) ? 2'b10 : 2'b01);
      acc <= 1'b1;
      psel <= s;
      @(posedge mclk);
    end
    acc <= 1'b0;
  endtask

  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid, sleep, auto_clock_gating, acc, psel} = '0;
    bready = 1'b1;
    rready = 1'b1;
    reset = 1'b1;
    ctrl_exp = 32'h0;
    en_exp = 12'hFFF;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    void'($urandom(32'h4C8E));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check_en();
    axi_read(`SCG1_OFS_CTRL, 32'h00000000, `SCG1_RESP_OKAY);
    axi_read(`SCG1_OFS_STATUS, 32'h00000000, `SCG1_RESP_OKAY);
    axi_read(`SCG1_OFS_MASK, 32'h00000000, `SCG1_RESP_OKAY);
    sleep <= 1'b1;
    auto_clock_gating <= 1'b1;
    check_en();
    periph_run(6, -1);
    $display("test reset done");
    axi_write(`SCG1_OFS_STATUS, 32'h00000003, 4'hF, `SCG1_RESP_OKAY);
    wr_ctrl(32'hFFFFFFFF, 4'hF);
    axi_read(`SCG1_OFS_CTRL, 32'h030F5033, `SCG1_RESP_OKAY);
    axi_read(`SCG1_OFS_STATUS, 32'h00000002, `SCG1_RESP_OKAY);
    wr_ctrl(32'h00000000, 4'h4);
    axi_read(`SCG1_OFS_CTRL, 32'h03005033, `SCG1_RESP_OKAY);
    axi_write(12'h300, 32'hFFFFFFFF, 4'hF, `SCG1_RESP_SLVERR);
    axi_read(12'h300, 32'h00000000, `SCG1_RESP_SLVERR);
    $display("test reserved and strobes done");
    for (int b = 0; b < 32; b++)
      if (`SCG1_CTRL_WMASK & (32'h1 << b))
      begin
        wr_ctrl(32'h1 << b, 4'hF);
        check_en();
        periph_run(16, -1);
      end
    $display("test single unit walk done");
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 2; k++)
      begin
        sleep <= m[1];
        auto_clock_gating <= m[0];
        wr_ctrl($urandom & `SCG1_CTRL_WMASK, 4'hF);
        axi_read(`SCG1_OFS_CTRL, ctrl_exp, `SCG1_RESP_OKAY);
        check_en();
        periph_run(8, -1);
      end
    $display("test random modes done");
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    ctrl_exp = 32'h00000000;
    @(posedge mclk);
    axi_read(`SCG1_OFS_CTRL, 32'h00000000, `SCG1_RESP_OKAY);
    axi_read(`SCG1_OFS_STATUS, 32'h00000000, `SCG1_RESP_OKAY);
    $display("test mid run reset done");
    sleep <= 1'b1;
    auto_clock_gating <= 1'b1;
    wr_ctrl(32'h00000000, 4'hF);
    check_en();
    axi_write(`SCG1_OFS_STATUS, 32'h00000003, 4'hF, `SCG1_RESP_OKAY);
    axi_write(`SCG1_OFS_MASK, 32'h00000001, 4'hF, `SCG1_RESP_OKAY);
    periph_run(1, 0);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    axi_read(`SCG1_OFS_STATUS, 32'h00000001, `SCG1_RESP_OKAY);
    axi_write(`SCG1_OFS_STATUS, 32'h00000001, 4'hF, `SCG1_RESP_OKAY);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    axi_write(`SCG1_OFS_MASK, 32'h00000000, 4'hF, `SCG1_RESP_OKAY);
    periph_run(1, 13);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    axi_read(`SCG1_OFS_STATUS, 32'h00000001, `SCG1_RESP_OKAY);
    repeat (3) @(posedge mclk);
    check(32'(pq.size() + bq.size() + rq.size()), 32'h0);
    $display("test interrupt done");
    end_sim();
  end
endmodule
